/* File: status_enable_and_message_queues.sv */
// Status enables, event latches, response queue and filtered error queue.
//
// Operation
// - Summary bit is OR of event AND enable.
// - Writing zero to an enable clears mask.
// - Enable values are full sixteen-bit range.
// - Reset and preset clear enables; CLS doesn't.
// - Enable query returns mask, mask unchanged.
// - Query replies go into response FIFO.
// - Writing response queue sets message available.
// - Reading pops reply; empty clears message available.
// - Enabled error entry sets error available.
// - Empty error queue clears error available.
// - Error queue holds ten code/text entries.
// - Single read returns oldest, then removes it.
// - Filling queue stores overflow code 350 last.
// - Empty after reset; empty read returns zero.
// - Codes signed: negative standard, positive vendor.
// - Reset admits errors, blocks status; commands don't.
// - Enable list admits listed codes, blocks others.
// - Disable list removes listed codes only.
// - Single codes and ranges decoded, one per command.
// - Empty enable list blocks every code.
// - Count and code-only queries supported.
// - Queue clear and CLS empty; preset doesn't.
// - Event bits latch until read or CLS.
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module status_enable_and_message_queues (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [3:0][15:0] event_set_i,
  input wire logic resp_push_i,
  input wire logic [15:0] resp_data_i,
  output logic resp_full_o,
  input wire logic err_push_i,
  input wire logic [9:0] err_code_i,
  input wire logic [7:0] err_text_i,
  output logic [3:0] summary_o,
  output logic message_available_flag_o,
  output logic error_available_flag_o
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Map a signed code onto a bitmap index by flipping the sign bit.
  function automatic logic [9:0] code_index(input logic [9:0] code);
    return {~code[9], code[8:0]};
  endfunction : code_index

  // Advance an error queue pointer, wrapping after the last slot.
  function automatic logic [3:0] errq_next(input logic [3:0] ptr);
    return (ptr == status_queues_pkg::ERRQ_LAST_PTR) ? 4'h0 : ptr + 4'h1;
  endfunction : errq_next

  // ==========================================================================
  // Command decode
  // ==========================================================================
  logic cmd_wr; // A write to the command register this cycle.
  logic cmd_cls; // Clear status strobe.
  logic cmd_preset; // Status preset strobe.
  logic cmd_qclear; // Error queue clear strobe.
  logic cmd_fempty; // Filter blank strobe.
  logic cmd_fadd; // Filter admit-range strobe.
  logic cmd_fdel; // Filter remove-range strobe.
  logic cmd_query; // Enable query strobe.

  assign cmd_wr = wr_i && (addr_i == status_queues_pkg::ADDR_CMD);
  assign cmd_cls = cmd_wr && wdata_i[status_queues_pkg::CMD_CLS];
  assign cmd_preset = cmd_wr && wdata_i[status_queues_pkg::CMD_PRESET];
  assign cmd_qclear = cmd_wr && wdata_i[status_queues_pkg::CMD_QCLEAR];
  assign cmd_fempty = cmd_wr && wdata_i[status_queues_pkg::CMD_FEMPTY];
  assign cmd_fadd = cmd_wr && wdata_i[status_queues_pkg::CMD_FADD];
  assign cmd_fdel = cmd_wr && wdata_i[status_queues_pkg::CMD_FDEL];
  assign cmd_query = cmd_wr && wdata_i[status_queues_pkg::CMD_ENQUERY];

  // ==========================================================================
  // Enable masks, event latches and summaries
  // ==========================================================================
  logic [3:0][15:0] en_r, en_nxt; // Enable masks, one per set.
  logic [3:0][15:0] ev_r, ev_nxt; // Latched event bits.
  logic [3:0] summary_r, summary_nxt; // Registered summary outputs.

  // Masks load from the bus, events latch; a set in the clear cycle wins.
  always_comb begin
    en_nxt = en_r;
    ev_nxt = ev_r;
    summary_nxt = '0;
    for (int k = 0; k < 4; k++) begin
      // Any 16-bit value is taken as is, zero included.
      if (wr_i && addr_i[3:2] == status_queues_pkg::ADDR_EN_BASE[3:2] &&
          addr_i[1:0] == 2'(k)) begin
        en_nxt[k] = wdata_i[15:0];
      end
      // Preset clears the masks; clear-status leaves them alone.
      if (cmd_preset) begin
        en_nxt[k] = status_queues_pkg::ENABLE_RST;
      end
      // Reading a set's event register, or clear-status, empties it.
      if ((rd_i && addr_i[3:2] == status_queues_pkg::ADDR_EVT_BASE[3:2] &&
           addr_i[1:0] == 2'(k)) || cmd_cls) begin
        ev_nxt[k] = status_queues_pkg::EVENT_RST;
      end
      ev_nxt[k] = ev_nxt[k] | event_set_i[k];
      summary_nxt[k] = |(ev_r[k] & en_r[k]);
    end
  end

  // Registers for the mask group.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_r <= {4{status_queues_pkg::ENABLE_RST}};
      ev_r <= {4{status_queues_pkg::EVENT_RST}};
      summary_r <= '0;
    end else begin
      en_r <= en_nxt;
      ev_r <= ev_nxt;
      summary_r <= summary_nxt;
    end
  end

  // ==========================================================================
  // Response queue
  // ==========================================================================
  logic [15:0] resp_mem [status_queues_pkg::RESP_DEPTH]; // Reply storage.
  logic [3:0] resp_wptr_r, resp_wptr_nxt; // Write pointer.
  logic [3:0] resp_rptr_r, resp_rptr_nxt; // Read pointer.
  logic [4:0] resp_cnt_r, resp_cnt_nxt; // Entries held.
  logic mav_r, mav_nxt; // Message available flag.
  logic rfull_r, rfull_nxt; // Queue full, told to the parser.
  logic qpend_r, qpend_nxt; // Enable query waiting for a free slot.
  logic [1:0] qsel_r, qsel_nxt; // Which mask the query asked for.
  logic resp_we; // Write a reply this cycle.
  logic [15:0] resp_wdata; // Reply being written.
  logic resp_pop; // Host took the head reply.

  // The parser owns the write port; a pending enable query slips in on the
  // first cycle the parser is quiet and a slot is free, so neither reply is lost.
  always_comb begin
    qpend_nxt = qpend_r;
    qsel_nxt = qsel_r;
    resp_we = 1'b0;
    resp_wdata = resp_data_i;
    resp_pop = rd_i && (addr_i == status_queues_pkg::ADDR_RESP) &&
               (resp_cnt_r != 5'h00);
    if (resp_push_i) begin
      resp_we = (!rfull_r) || resp_pop;
    end else if (qpend_r) begin
      resp_wdata = en_r[qsel_r];
      resp_we = (!rfull_r) || resp_pop;
      qpend_nxt = !resp_we;
    end
    if (cmd_query) begin
      qpend_nxt = 1'b1;
      qsel_nxt = wdata_i[status_queues_pkg::CMD_QSEL_LSB +: 2];
    end
    resp_wptr_nxt = resp_we ? resp_wptr_r + 4'h1 : resp_wptr_r;
    resp_rptr_nxt = resp_pop ? resp_rptr_r + 4'h1 : resp_rptr_r;
    resp_cnt_nxt = resp_cnt_r + {4'h0, resp_we} - {4'h0, resp_pop};
    // The flag follows the count, so a write in a popping cycle keeps it.
    mav_nxt = (resp_cnt_nxt != 5'h00);
    rfull_nxt = (resp_cnt_nxt == status_queues_pkg::RESP_FULL_CNT);
  end

  // Registers for the response queue.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      resp_wptr_r <= '0;
      resp_rptr_r <= '0;
      resp_cnt_r <= '0;
      mav_r <= 1'b0;
      rfull_r <= 1'b0;
      qpend_r <= 1'b0;
      qsel_r <= '0;
    end else begin
      resp_wptr_r <= resp_wptr_nxt;
      resp_rptr_r <= resp_rptr_nxt;
      resp_cnt_r <= resp_cnt_nxt;
      mav_r <= mav_nxt;
      rfull_r <= rfull_nxt;
      qpend_r <= qpend_nxt;
      qsel_r <= qsel_nxt;
    end
  end

  // Reply storage has no reset; the pointers say what is valid.
  always_ff @(posedge clk_i) begin
    if (resp_we) begin
      resp_mem[resp_wptr_r] <= resp_wdata;
    end
  end

  // ==========================================================================
  // Code filter walker
  // ==========================================================================
  logic [1023:0] filt_r, filt_nxt; // One admit bit per signed code.
  status_queues_pkg::walk_state_t wstate_r, wstate_nxt; // Walker state.
  logic signed [9:0] wcode_r, wcode_nxt; // Code being written.
  logic signed [9:0] wend_r, wend_nxt; // Last code of the range.
  logic wval_r, wval_nxt; // Admit (1) or remove (0).
  logic [31:0] range_r, range_nxt; // Range bounds from software.
  logic signed [9:0] rlo; // Lower bound as written.
  logic signed [9:0] rhi; // Upper bound as written.

  assign rlo = range_r[status_queues_pkg::RANGE_LO_LSB +: 10];
  assign rhi = range_r[status_queues_pkg::RANGE_HI_LSB +: 10];

  // A range is written one code per clock; this trades up to 1024 cycles
  // per range for a single write port on the bitmap.
  always_comb begin
    filt_nxt = filt_r;
    wstate_nxt = wstate_r;
    wcode_nxt = wcode_r;
    wend_nxt = wend_r;
    wval_nxt = wval_r;
    range_nxt = range_r;
    if (wr_i && addr_i == status_queues_pkg::ADDR_RANGE) begin
      range_nxt = wdata_i;
    end
    // An enable list starts from nothing, so an empty list blocks all.
    if (cmd_fempty) begin
      filt_nxt = '0;
    end
    case (wstate_r)
      status_queues_pkg::WALK_IDLE: begin
        // Bounds may come in either order, as in a descending range.
        if (cmd_fadd || cmd_fdel) begin
          wcode_nxt = (rlo < rhi) ? rlo : rhi;
          wend_nxt = (rlo < rhi) ? rhi : rlo;
          wval_nxt = cmd_fadd;
          wstate_nxt = status_queues_pkg::WALK_RUN;
        end
      end
      status_queues_pkg::WALK_RUN: begin
        // Only codes inside the range are touched.
        filt_nxt[code_index(wcode_r)] = wval_r;
        if (wcode_r == wend_r) begin
          wstate_nxt = status_queues_pkg::WALK_IDLE;
        end else begin
          wcode_nxt = wcode_r + 10'sd1;
        end
      end
      default: begin
        wstate_nxt = status_queues_pkg::WALK_IDLE;
      end
    endcase
  end

  // Registers for the filter; neither clear-status nor preset reach it.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      filt_r <= status_queues_pkg::FILTER_RST;
      wstate_r <= status_queues_pkg::WALK_IDLE;
      wcode_r <= '0;
      wend_r <= '0;
      wval_r <= 1'b0;
      range_r <= '0;
    end else begin
      filt_r <= filt_nxt;
      wstate_r <= wstate_nxt;
      wcode_r <= wcode_nxt;
      wend_r <= wend_nxt;
      wval_r <= wval_nxt;
      range_r <= range_nxt;
    end
  end

  // ==========================================================================
  // Error queue
  // ==========================================================================
  logic [9:0] ecode_mem [status_queues_pkg::ERRQ_DEPTH]; // Signed codes.
  logic [7:0] etext_mem [status_queues_pkg::ERRQ_DEPTH]; // Text handles.
  logic [3:0] ehead_r, ehead_nxt; // Oldest entry.
  logic [3:0] etail_r, etail_nxt; // Next free slot.
  logic [3:0] ecnt_r, ecnt_nxt; // Entries held, 0 to 10.
  logic eav_r, eav_nxt; // Error available flag.
  logic admit; // Incoming code passes the filter.
  logic epop; // Host read of the oldest entry.
  logic eclr; // Queue empties this cycle.
  logic [3:0] eff_cnt; // Count once this cycle's pop is taken.
  logic ewe; // Store an entry this cycle.
  logic [3:0] ewaddr; // Where it goes.
  logic [9:0] ewcode; // Code stored.
  logic [7:0] ewtext; // Text stored.

  // Pop, clear and push all resolve here so the flag sees the final count.
  always_comb begin
    admit = err_push_i && filt_r[code_index(err_code_i)];
    epop = rd_i && (ecnt_r != 4'h0) &&
           (addr_i == status_queues_pkg::ADDR_ERR_NEXT ||
            addr_i == status_queues_pkg::ADDR_ERR_CODE);
    eclr = cmd_cls || cmd_qclear;
    eff_cnt = ecnt_r - {3'h0, epop};
    ewcode = err_code_i;
    ewtext = err_text_i;
    ewe = 1'b0;
    ewaddr = etail_r;
    ehead_nxt = epop ? errq_next(ehead_r) : ehead_r;
    etail_nxt = etail_r;
    ecnt_nxt = eff_cnt;
    if (eclr) begin
      // A message arriving with the clear survives as the only entry.
      ehead_nxt = 4'h0;
      ewaddr = 4'h0;
      ewe = admit;
      etail_nxt = admit ? 4'h1 : 4'h0;
      ecnt_nxt = admit ? 4'h1 : 4'h0;
    end else if (admit && ecnt_r != status_queues_pkg::ERRQ_FULL_CNT) begin
      // A full queue drops input until a read frees a slot.
      ewe = 1'b1;
      if (eff_cnt == status_queues_pkg::ERRQ_LAST_CNT) begin
        ewcode = status_queues_pkg::OVERFLOW_CODE;
        ewtext = status_queues_pkg::OVERFLOW_TEXT;
      end
      etail_nxt = errq_next(etail_r);
      ecnt_nxt = eff_cnt + 4'h1;
    end
    eav_nxt = (ecnt_nxt != 4'h0);
  end

  // Registers for the error queue; preset does not touch them.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ehead_r <= '0;
      etail_r <= '0;
      ecnt_r <= '0;
      eav_r <= 1'b0;
    end else begin
      ehead_r <= ehead_nxt;
      etail_r <= etail_nxt;
      ecnt_r <= ecnt_nxt;
      eav_r <= eav_nxt;
    end
  end

  // Entry storage has no reset; the count says what is valid.
  always_ff @(posedge clk_i) begin
    if (ewe) begin
      ecode_mem[ewaddr] <= ewcode;
      etext_mem[ewaddr] <= ewtext;
    end
  end

  // ==========================================================================
  // Read data path
  // ==========================================================================
  logic [31:0] rdata_r, rdata_nxt; // Read data, valid one cycle after rd_i.
  logic [9:0] head_code; // Oldest code, or the no-error code.
  logic [7:0] head_text; // Oldest text, or the no-error text.

  // Read data are formed from the state before this cycle's pops.
  always_comb begin
    head_code = status_queues_pkg::NO_ERROR_CODE;
    head_text = status_queues_pkg::NO_ERROR_TEXT;
    if (ecnt_r != 4'h0) begin
      head_code = ecode_mem[ehead_r];
      head_text = etext_mem[ehead_r];
    end
    rdata_nxt = '0;
    if (rd_i) begin
      case (addr_i)
        status_queues_pkg::ADDR_RESP: begin
          if (resp_cnt_r != 5'h00) begin
            rdata_nxt = {16'h0000, resp_mem[resp_rptr_r]};
          end
        end
        status_queues_pkg::ADDR_ERR_NEXT: begin
          rdata_nxt = {8'h00, head_text, {6{head_code[9]}}, head_code};
        end
        status_queues_pkg::ADDR_ERR_CODE: begin
          rdata_nxt = {16'h0000, {6{head_code[9]}}, head_code};
        end
        status_queues_pkg::ADDR_ERR_COUNT: begin
          rdata_nxt = {28'h0000000, ecnt_r};
        end
        status_queues_pkg::ADDR_RANGE: begin
          rdata_nxt = range_r;
        end
        status_queues_pkg::ADDR_STATUS: begin
          rdata_nxt[status_queues_pkg::ST_MAV] = mav_r;
          rdata_nxt[status_queues_pkg::ST_EAV] = eav_r;
          rdata_nxt[status_queues_pkg::ST_BUSY] =
            (wstate_r == status_queues_pkg::WALK_RUN);
          rdata_nxt[status_queues_pkg::ST_RFULL] = rfull_r;
          rdata_nxt[status_queues_pkg::ST_ECNT_LSB +: 4] = ecnt_r;
          rdata_nxt[status_queues_pkg::ST_RCNT_LSB +: 5] = resp_cnt_r;
          rdata_nxt[status_queues_pkg::ST_SUM_LSB +: 4] = summary_r;
        end
        default: begin
          // Enables answer in place; events read then clear above.
          if (addr_i[3:2] == status_queues_pkg::ADDR_EN_BASE[3:2]) begin
            rdata_nxt = {16'h0000, en_r[addr_i[1:0]]};
          end else if (addr_i[3:2] ==
                       status_queues_pkg::ADDR_EVT_BASE[3:2]) begin
            rdata_nxt = {16'h0000, ev_r[addr_i[1:0]]};
          end
        end
      endcase
    end
  end

  // Read data register; it holds zero in the cycle after one with no read.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign rdata_o = rdata_r;
  assign resp_full_o = rfull_r;
  assign summary_o = summary_r;
  assign message_available_flag_o = mav_r;
  assign error_available_flag_o = eav_r;

endmodule : status_enable_and_message_queues

`default_nettype wire

/* File: status_queues_pkg.sv */
// Constants and types shared by the status enable and message queue block.
`default_nettype none

package status_queues_pkg;

  // ==========================================================================
  // Bus and mask widths
  // ==========================================================================
  localparam int unsigned DATA_W = 32;   // Register data width.
  localparam int unsigned ADDR_W = 4;    // Register word index width.
  localparam int unsigned MASK_W = 16;   // Enable and event register width.
  localparam int unsigned NUM_SETS = 4;  // Standard, operation, meas, quest.

  // ==========================================================================
  // Register word indexes
  // ==========================================================================
  localparam logic [3:0] ADDR_EN_BASE = 4'h0;   // Enables at 0..3.
  localparam logic [3:0] ADDR_EVT_BASE = 4'h4;  // Events at 4..7.
  localparam logic [3:0] ADDR_RESP = 4'h8;      // Response queue head.
  localparam logic [3:0] ADDR_ERR_NEXT = 4'h9;  // Oldest error, code + text.
  localparam logic [3:0] ADDR_ERR_CODE = 4'ha;  // Oldest error, code only.
  localparam logic [3:0] ADDR_ERR_COUNT = 4'hb; // Entries in error queue.
  localparam logic [3:0] ADDR_CMD = 4'hc;       // Command strobes.
  localparam logic [3:0] ADDR_RANGE = 4'hd;     // Code range for filter.
  localparam logic [3:0] ADDR_STATUS = 4'he;    // Block state.

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [15:0] ENABLE_RST = 16'h0000;
  localparam logic [15:0] EVENT_RST = 16'h0000;

  // ==========================================================================
  // Command register bit positions
  // ==========================================================================
  localparam int unsigned CMD_CLS = 0;        // Clear status.
  localparam int unsigned CMD_PRESET = 1;     // Status preset.
  localparam int unsigned CMD_QCLEAR = 2;     // Clear error queue.
  localparam int unsigned CMD_FEMPTY = 3;     // Block every code.
  localparam int unsigned CMD_FADD = 4;       // Admit the range.
  localparam int unsigned CMD_FDEL = 5;       // Remove the range.
  localparam int unsigned CMD_ENQUERY = 6;    // Queue an enable value.
  localparam int unsigned CMD_QSEL_LSB = 8;   // Two-bit set select.

  // ==========================================================================
  // Range register and status register fields
  // ==========================================================================
  localparam int unsigned RANGE_LO_LSB = 0;
  localparam int unsigned RANGE_HI_LSB = 16;
  localparam int unsigned ST_MAV = 0;
  localparam int unsigned ST_EAV = 1;
  localparam int unsigned ST_BUSY = 2;
  localparam int unsigned ST_RFULL = 3;
  localparam int unsigned ST_ECNT_LSB = 4;
  localparam int unsigned ST_RCNT_LSB = 8;
  localparam int unsigned ST_SUM_LSB = 16;

  // ==========================================================================
  // Response queue
  // ==========================================================================
  localparam int unsigned RESP_DEPTH = 16;
  localparam int unsigned RESP_PTR_W = 4;
  localparam int unsigned RESP_CNT_W = 5;
  localparam logic [4:0] RESP_FULL_CNT = 5'h10;

  // ==========================================================================
  // Error queue
  // ==========================================================================
  localparam int unsigned ERRQ_DEPTH = 10;
  localparam int unsigned ERRQ_PTR_W = 4;
  localparam logic [3:0] ERRQ_FULL_CNT = 4'ha;
  localparam logic [3:0] ERRQ_LAST_CNT = 4'h9;
  localparam logic [3:0] ERRQ_LAST_PTR = 4'h9;
  localparam int unsigned CODE_W = 10;
  localparam int unsigned TEXT_W = 8;
  localparam logic signed [9:0] OVERFLOW_CODE = 10'sd350;
  localparam logic signed [9:0] NO_ERROR_CODE = 10'sd0;
  localparam logic [7:0] OVERFLOW_TEXT = 8'h01;
  localparam logic [7:0] NO_ERROR_TEXT = 8'h00;

  // ==========================================================================
  // Code filter
  // ==========================================================================
  localparam int unsigned FILTER_BITS = 1024;
  localparam int unsigned CODE_BIAS = 512;
  localparam int unsigned STATUS_MIN_CODE = 100;  // Codes from here up.
  localparam logic [1023:0] FILTER_RST =
    {1024{1'b1}} >> (FILTER_BITS - CODE_BIAS - STATUS_MIN_CODE);

  // Filter walker states.
  typedef enum logic [0:0] {
    WALK_IDLE = 1'b0,
    WALK_RUN = 1'b1
  } walk_state_t;

endpackage : status_queues_pkg

`default_nettype wire

/* File: status_queues_monitor.sv */
// Checker on the port relations of the status block.
`timescale 1ns/1ps
`default_nettype none
module status_queues_monitor (
  input wire logic clk_i, input wire logic rst_i,
  input wire logic wr_i, input wire logic rd_i,
  input wire logic [3:0] addr_i, input wire logic [31:0] rdata_o,
  input wire logic resp_push_i, input wire logic resp_full_o,
  input wire logic err_push_i, input wire logic message_available_flag_o,
  input wire logic error_available_flag_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic message_available_flag = message_available_flag_o;
  wire logic error_available_flag = error_available_flag_o;
  // ==========================================================================
  // Reads of empty queues, and cycles with no read, hand back zero.
  sequence s_rd_resp; rd_i && addr_i == 4'h8 && !message_available_flag; endsequence
  sequence s_rd_err; rd_i && addr_i == 4'h9 && !error_available_flag; endsequence
  property p_resp_empty; s_rd_resp |=> rdata_o == 32'h0; endproperty
  a_resp_empty: assert property (p_resp_empty) else $error("resp");
  property p_err_empty; s_rd_err |=> rdata_o == 32'h0; endproperty
  a_err_empty: assert property (p_err_empty) else $error("err");
  property p_idle; !$past(rd_i) |-> rdata_o == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  // ==========================================================================
  // Flags follow pushes, reads and command writes within two cycles; count reads stay at ten or less.
  property p_mav_set; resp_push_i && !resp_full_o |-> ##[1:2] message_available_flag; endproperty
  a_mav_set: assert property (p_mav_set) else $error("mav set");
  property p_mav_clr; $fell(message_available_flag) |-> $past(rd_i) || $past(rd_i, 2); endproperty
  a_mav_clr: assert property (p_mav_clr) else $error("mav clr");
  property p_eav_set; $rose(error_available_flag) |-> $past(err_push_i) || $past(err_push_i, 2);
  endproperty
  a_eav_set: assert property (p_eav_set) else $error("eav set");
  property p_eav_clr; $fell(error_available_flag) |->
    $past(rd_i | wr_i) || $past(rd_i | wr_i, 2); endproperty
  a_eav_clr: assert property (p_eav_clr) else $error("eav clr");
  property p_cnt; rd_i && addr_i == 4'hb |=> rdata_o <= 32'ha; endproperty
  a_cnt: assert property (p_cnt) else $error("count");
endmodule : status_queues_monitor
`default_nettype wire

/* File: host_err_source.sv */
// Host-side model that posts error and status messages.
`timescale 1ns/1ps
`default_nettype none
module host_err_source (
  input wire logic clk_i,
  output logic err_push_o,
  output logic [9:0] err_code_o,
  output logic [7:0] err_text_o
);
  initial {err_push_o, err_code_o, err_text_o} = '0;
  // One-cycle push; the code line is scrambled once the push is over.
  task automatic send(logic [9:0] c, logic [7:0] t);
    @(posedge clk_i);
    {err_push_o, err_code_o, err_text_o} <= {1'b1, c, t};
    @(posedge clk_i);
    {err_push_o, err_code_o} <= {1'b0, ~c};
  endtask : send
endmodule : host_err_source
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the status enable and message queue block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, resp_full_o, message_available_flag, error_available_flag;
  logic [3:0] addr_i = 4'h0, summary_o;
  logic [31:0] wdata_i = 32'h0, rdata_o, v;
  logic [3:0][15:0] event_set_i = '0;
  logic err_push_i, resp_push_i = 1'b0;
  logic [15:0] resp_data_i = 16'h0;
  logic [9:0] err_code_i;
  logic [7:0] err_text_i;
  int err_total = 0, cmp_count = 0;
  initial forever #20 clk_i = ~clk_i;
  status_enable_and_message_queues i_status_enable_and_message_queues (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .event_set_i(event_set_i),
    .resp_push_i(resp_push_i), .resp_data_i(resp_data_i),
    .resp_full_o(resp_full_o),
    .err_push_i(err_push_i), .err_code_i(err_code_i), .summary_o(summary_o),
    .err_text_i(err_text_i), .message_available_flag_o(message_available_flag),
    .error_available_flag_o(error_available_flag));
  host_err_source i_host (.clk_i(clk_i), .err_push_o(err_push_i),
    .err_code_o(err_code_i), .err_text_o(err_text_i));
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge clk_i);
    {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // Read data is sampled mid-cycle, in the only cycle where it stands.
  task automatic rd(logic [3:0] a);
    @(posedge clk_i);
    {rd_i, addr_i} <= {1'b1, a};
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    v = rdata_o;
  endtask : rd
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (4000) @(posedge clk_i);
    err_total++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wr(4'h1, 32'hffff);
    rd(4'h1);
    chk("en1", v, 32'hffff);
    wr(4'h1, 32'h0);
    rd(4'h1);
    chk("en1", v, 32'h0);
    wr(4'h0, 32'h4);
    @(posedge clk_i);
    event_set_i[0] <= 16'h4;
    @(posedge clk_i);
    event_set_i[0] <= 16'h0;
    repeat (3) @(posedge clk_i);
    chk("sum", {28'h0, summary_o}, 32'h1);
    wr(4'hc, 32'h1);
    rd(4'h0);
    chk("en0", v, 32'h4);
    wr(4'hc, 32'h2);
    rd(4'h0);
    chk("en0", v, 32'h0);
    $display("test masks done");
    wr(4'h3, 32'ha5c3);
    wr(4'hc, 32'h340);
    repeat (3) @(posedge clk_i);
    chk("mav", {31'h0, message_available_flag}, 32'h1);
    rd(4'h8);
    chk("reply", {16'h0, v[15:0]}, 32'ha5c3);
    rd(4'h8);
    chk("reply", v, 32'h0);
    chk("mav", {31'h0, message_available_flag}, 32'h0);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_i);
      {resp_push_i, resp_data_i} <= {1'b1, 16'(i + 1)};
    end
    @(posedge clk_i);
    resp_push_i <= 1'b0;
    @(negedge clk_i);
    chk("full", {31'h0, resp_full_o}, 32'h1);
    rd(4'h8);
    chk("reply", v, 32'h1);
    $display("test reply done");
    for (int i = 0; i < 12; i++) i_host.send(10'h3ff - 10'(i), 8'h10);
    rd(4'hb);
    chk("count", v, 32'ha);
    for (int i = 1; i < 10; i++) begin
      rd(4'ha);
      chk("code", v, {16'h0, 16'(-i)});
    end
    rd(4'h9);
    chk("ovf", v, 32'h0001015e);
    rd(4'h9);
    chk("none", v, 32'h0);
    chk("eav", {31'h0, error_available_flag}, 32'h0);
    i_host.send(10'd200, 8'h2);
    i_host.send(10'h3fb, 8'h3);
    repeat (2) @(posedge clk_i);
    chk("eav", {31'h0, error_available_flag}, 32'h1);
    rd(4'hb);
    chk("count", v, 32'h1);
    wr(4'hc, 32'h1);
    rd(4'hb);
    chk("count", v, 32'h0);
    wr(4'hd, 32'h00c800c8);
    wr(4'hc, 32'h10);
    i_host.send(10'd200, 8'h4);
    wr(4'hc, 32'h8);
    i_host.send(10'h3fb, 8'h5);
    rd(4'hb);
    chk("count", v, 32'h1);
    $display("test queue done");
    report_and_stop();
  end
endmodule : testbench
bind status_enable_and_message_queues status_queues_monitor i_mon (
  .clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i),
  .rdata_o(rdata_o), .resp_push_i(resp_push_i), .resp_full_o(resp_full_o),
  .err_push_i(err_push_i), .message_available_flag_o(message_available_flag_o),
  .error_available_flag_o(error_available_flag_o));
`default_nettype wire
